// ### inc/sysif_pkg.sv
package sysif_pkg;

  // Boot serial clock divide ratio and stream length
  localparam int MODE_DIV = 256;
  localparam int MODE_STREAM_BITS = 256;
  localparam int MODE_KEEP_BITS = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ADDR = 8'h04;
  localparam logic [7:0] ADDR_WDATA = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;

  // Control register fields
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_CMD_LSB = 4;
  localparam int CTRL_DID_LSB = 16;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_BOOT_DONE = 1;
  localparam int STAT_CORE_RUN = 2;
  localparam int STAT_RD_DONE = 3;
  localparam int STAT_PAR_ERR = 4;
  localparam int STAT_EXT_SEEN = 5;
  localparam int STAT_MODE_BAD = 6;
  localparam int STAT_SLAVE = 7;

  // Boot mode fields and codes
  localparam int MODE_WB_LSB = 1;
  localparam int MODE_MULT_LSB = 5;
  localparam int MODE_WP_LSB = 9;
  localparam logic [2:0] MULT_RSVD = 3'h7;
  localparam logic [3:0] MULT_BASE = 4'h2;
  localparam logic [3:0] WB_MAX = 4'h8;
  localparam logic [1:0] WP_RSVD = 2'h1;

  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [15:0] MODE_RST = 16'h0;
  localparam logic [8:0] CMD_RST = 9'h0;

  typedef struct packed {
    logic [8:0] cmd;
    logic [3:0] check;
    logic [31:0] data;
  } bus_word_t;

  typedef struct packed {
    logic [1:0] wr_proto;
    logic [2:0] mult;
    logic [3:0] wb_pattern;
  } boot_mode_t;

  typedef enum {BUS_IDLE, BUS_WAIT_RDY, BUS_ADDR, BUS_DATA, BUS_RD_WAIT, BUS_SLAVE} bus_state_t;
  typedef enum {BOOT_WAIT_SUPPLY, BOOT_SHIFT, BOOT_DONE} boot_state_t;

  // Even parity per byte lane
  function automatic logic [3:0] lane_parity(input logic [31:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

endpackage

// ### hdl/sync2.sv
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // Reference clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= RST;
      q <= RST;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ### hdl/cpu_system_interface_boot.sv
// Contract
// (R1) Agent pulls ext_request_n low to submit its own request.
// (R2) Device pulls release_n low when handing the bus over, going slave.
// (R3) Agent pulls read_accept_n low only when it can take a read.
// (R4) Agent pulls write_accept_n low only when it can take a write.
// (R5) Agent pulls inbound_valid_n low while driving valid bus words.
// (R6) Device pulls outbound_valid_n low while driving valid bus words.
// (R7) Addresses and data share one 32-bit bidirectional bus.
// (R8) A 4-bit check bus carries byte parity during data cycles.
// (R9) A 9-bit bidirectional command/identifier bus runs beside the data bus.
// (R10) Command parity is ignored on input and driven zero on output.
// (R11) Outputs timed to the reference clock; core factor set at boot.
// (R12) Supply-good assertion starts reading the serial boot stream.
// (R13) Power-on reset asserted on cold reset, released synchronously.
// (R14) Reset asserted for every reset, released synchronously.
// (R15) Boot serial clock is the reference clock divided by 256.
// (R16) Boot configuration arrives serially, one bit per boot clock.
// (R17) Pins with asterisk names are active low.
// (R18) Mode bits 7:5 pick multiplier 2..8; code 7 reserved.
// (R19) Mode bits 4:1 pick writeback pattern 0..8; 9..15 reserved.
// (R20) Mode bits 10:9 pick write protocol; code 01 reserved.
// (R21) Core stays in reset until the whole boot stream is latched.
module cpu_system_interface_boot #(
  parameter int STREAM_BITS = sysif_pkg::MODE_STREAM_BITS
) (
  input wire logic clk, // Reference clock, 125 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Register read data, cycle after strobe
  input wire logic ext_request_n, // Agent request pin
  input wire logic read_accept_n, // Agent read ready pin
  input wire logic write_accept_n, // Agent write ready pin
  input wire logic inbound_valid_n, // Agent valid pin
  output logic outbound_valid_n, // Device valid pin
  output logic release_n, // Bus release pin
  input wire logic [31:0] mux_addr_data_bus_in, // Address/data bus input
  output logic [31:0] mux_addr_data_bus_out, // Address/data bus output
  output logic mux_addr_data_bus_oe, // Address/data bus enable
  input wire logic [3:0] addr_data_check_bus_in, // Check bus input
  output logic [3:0] addr_data_check_bus_out, // Check bus output
  output logic addr_data_check_bus_oe, // Check bus enable
  input wire logic [8:0] command_id_bus_in, // Command bus input
  output logic [8:0] command_id_bus_out, // Command bus output
  output logic command_id_bus_oe, // Command bus enable
  input wire logic command_bus_parity_in, // Command parity input, unused
  output logic command_bus_parity_out, // Command parity output
  output logic command_bus_parity_oe, // Command parity enable
  input wire logic supply_good, // Supply good pin, active high
  input wire logic power_on_reset_n, // Cold reset pin
  input wire logic reset_n, // Reset pin
  output logic boot_serial_clock, // Boot mode serial clock
  input wire logic boot_mode_data, // Boot mode serial data
  output logic core_reset_n, // Core reset, active low
  output logic [3:0] core_clock_factor // Core clock multiplier, 0 if reserved
);

  // Refuse stream lengths the bit counter cannot serve
  if (STREAM_BITS < sysif_pkg::MODE_KEEP_BITS || STREAM_BITS > 65535)
  begin
    $error("STREAM_BITS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [6:0] ctl_s;
  sysif_pkg::bus_word_t in_s;

  sync2 #(.W(7), .RST(7'h7f)) u_sync_ctl (
    .clk(clk),
    .rstn(rstn),
    .d({ext_request_n, read_accept_n, write_accept_n, inbound_valid_n, power_on_reset_n, reset_n, boot_mode_data}),
    .q(ctl_s)
  );

  sync2 #(.W(45), .RST('0)) u_sync_bus (
    .clk(clk),
    .rstn(rstn),
    .d({command_id_bus_in, addr_data_check_bus_in, mux_addr_data_bus_in}),
    .q(in_s)
  );

  logic supply_s;
  sync2 #(.W(1), .RST(1'b0)) u_sync_sup (
    .clk(clk),
    .rstn(rstn),
    .d(supply_good),
    .q(supply_s)
  );

  // Active-low pins turned into active-high requests
  wire ext_req = ~ctl_s[6]; // see (R1) (R17)
  wire rd_ok = ~ctl_s[5]; // see (R3)
  wire wr_ok = ~ctl_s[4]; // see (R4)
  wire in_valid = ~ctl_s[3]; // see (R5)
  wire cold_rst = ~ctl_s[2]; // see (R13)
  wire any_rst = ~ctl_s[1]; // see (R14)
  wire mode_bit = ctl_s[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Boot mode stream

  sysif_pkg::boot_state_t boot_r, boot_nxt;
  logic [7:0] div_r;
  logic mclk_r;
  logic [15:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic [15:0] mode_r;
  logic boot_done_r;
  logic [3:0] factor_r;
  logic core_rst_n_r;

  wire [7:0] div_last = 8'(sysif_pkg::MODE_DIV - 1);
  wire [7:0] div_half = 8'(sysif_pkg::MODE_DIV / 2 - 1);
  wire mclk_rise = (boot_r == sysif_pkg::BOOT_SHIFT) && (div_r == div_half);
  // Frame ends once the last boot clock has finished its full high phase
  wire stream_end = (boot_r == sysif_pkg::BOOT_SHIFT) && (div_r == div_last) && (bit_cnt_r == 16'(STREAM_BITS));
  wire [15:0] shift_nxt = {mode_bit, shift_r[15:1]};

  sysif_pkg::boot_mode_t mode_f;
  assign mode_f.wb_pattern = mode_r[sysif_pkg::MODE_WB_LSB +: 4];
  assign mode_f.mult = mode_r[sysif_pkg::MODE_MULT_LSB +: 3];
  assign mode_f.wr_proto = mode_r[sysif_pkg::MODE_WP_LSB +: 2];

  wire mult_bad = mode_f.mult == sysif_pkg::MULT_RSVD; // see (R18)
  wire wb_bad = mode_f.wb_pattern > sysif_pkg::WB_MAX; // see (R19)
  wire wp_bad = mode_f.wr_proto == sysif_pkg::WP_RSVD; // see (R20)
  wire mode_bad = boot_done_r && (mult_bad || wb_bad || wp_bad);
  wire [3:0] factor_nxt = mult_bad ? 4'h0 : sysif_pkg::MULT_BASE + {1'b0, mode_f.mult}; // see (R11) (R18)
  wire core_run_nxt = boot_done_r && !any_rst && !cold_rst; // see (R21)

  always_comb
  begin
    boot_nxt = boot_r;
    unique case (boot_r)
      sysif_pkg::BOOT_WAIT_SUPPLY:
      begin
        if (supply_s)
        begin
          boot_nxt = sysif_pkg::BOOT_SHIFT; // see (R12)
        end
      end
      sysif_pkg::BOOT_SHIFT:
      begin
        if (stream_end)
        begin
          boot_nxt = sysif_pkg::BOOT_DONE;
        end
      end
      sysif_pkg::BOOT_DONE:
      begin
        boot_nxt = sysif_pkg::BOOT_DONE;
      end
    endcase
    if (cold_rst || !supply_s)
    begin
      boot_nxt = sysif_pkg::BOOT_WAIT_SUPPLY; // see (R13)
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      boot_r <= sysif_pkg::BOOT_WAIT_SUPPLY;
      div_r <= 8'h0;
      mclk_r <= 1'b0;
      bit_cnt_r <= 16'h0;
      shift_r <= sysif_pkg::MODE_RST;
      mode_r <= sysif_pkg::MODE_RST;
      boot_done_r <= 1'b0;
      factor_r <= 4'h0;
      core_rst_n_r <= 1'b0;
    end
    else
    begin
      boot_r <= boot_nxt;
      div_r <= (boot_r == sysif_pkg::BOOT_SHIFT) ? div_r + 8'h1 : 8'h0; // see (R15)
      mclk_r <= (boot_r == sysif_pkg::BOOT_SHIFT) && (div_r >= div_half) && (div_r != div_last);
      if (boot_r != sysif_pkg::BOOT_SHIFT)
      begin
        bit_cnt_r <= 16'h0;
      end
      else if (mclk_rise)
      begin
        bit_cnt_r <= bit_cnt_r + 16'h1;
        if (bit_cnt_r < 16'(sysif_pkg::MODE_KEEP_BITS))
        begin
          shift_r <= shift_nxt; // see (R16)
        end
      end
      if (stream_end)
      begin
        mode_r <= shift_r;
      end
      boot_done_r <= boot_nxt == sysif_pkg::BOOT_DONE;
      factor_r <= boot_done_r ? factor_nxt : 4'h0;
      core_rst_n_r <= core_run_nxt;
    end
  end

  assign boot_serial_clock = mclk_r;
  assign core_reset_n = core_rst_n_r;
  assign core_clock_factor = factor_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [31:0] ctrl_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [8:0] rcmd_r;
  logic rd_done_r, par_err_r, ext_seen_r;
  logic [31:0] reg_rdata_r;

  wire hit_ctrl = reg_addr == sysif_pkg::ADDR_CTRL;
  wire hit_addr = reg_addr == sysif_pkg::ADDR_ADDR;
  wire hit_wdata = reg_addr == sysif_pkg::ADDR_WDATA;
  wire hit_rdata = reg_addr == sysif_pkg::ADDR_RDATA;
  wire hit_status = reg_addr == sysif_pkg::ADDR_STATUS;
  wire hit_mode = reg_addr == sysif_pkg::ADDR_MODE;
  wire wr_ctrl = reg_wr && hit_ctrl;
  wire clr_status = reg_wr && hit_status;
  wire start_rd = wr_ctrl && reg_wdata[sysif_pkg::CTRL_RD_BIT];
  wire start_wr = wr_ctrl && reg_wdata[sysif_pkg::CTRL_WR_BIT] && !reg_wdata[sysif_pkg::CTRL_RD_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus engine

  sysif_pkg::bus_state_t bus_r, bus_nxt;
  logic is_wr_r;
  sysif_pkg::bus_word_t out_r, out_nxt;
  logic drive_r, drive_nxt;
  logic ovalid_r, ovalid_nxt;
  logic rel_r, rel_nxt;

  wire core_run = core_rst_n_r && core_run_nxt;
  wire [8:0] addr_cmd = ctrl_r[sysif_pkg::CTRL_CMD_LSB +: 9];
  wire [8:0] data_id = ctrl_r[sysif_pkg::CTRL_DID_LSB +: 9];
  wire in_take = in_valid && (bus_r == sysif_pkg::BUS_RD_WAIT || bus_r == sysif_pkg::BUS_SLAVE);
  wire in_par_bad = in_s.check != sysif_pkg::lane_parity(in_s.data); // see (R8)
  wire rd_finish = in_valid && bus_r == sysif_pkg::BUS_RD_WAIT;
  wire accept_ok = is_wr_r ? wr_ok : rd_ok; // see (R3) (R4)
  wire busy = bus_r != sysif_pkg::BUS_IDLE;

  always_comb
  begin
    bus_nxt = bus_r;
    out_nxt = out_r;
    drive_nxt = 1'b0;
    ovalid_nxt = 1'b0;
    rel_nxt = 1'b0;
    unique case (bus_r)
      sysif_pkg::BUS_IDLE:
      begin
        drive_nxt = 1'b1;
        if (!core_run)
        begin
          drive_nxt = 1'b0;
        end
        else if (ext_req)
        begin
          bus_nxt = sysif_pkg::BUS_SLAVE; // see (R1)
          rel_nxt = 1'b1; // see (R2)
          drive_nxt = 1'b0;
        end
        else if (start_rd || start_wr)
        begin
          bus_nxt = sysif_pkg::BUS_WAIT_RDY;
        end
      end
      sysif_pkg::BUS_WAIT_RDY:
      begin
        drive_nxt = 1'b1;
        if (accept_ok)
        begin
          bus_nxt = sysif_pkg::BUS_ADDR;
          out_nxt.data = addr_r; // see (R7)
          out_nxt.cmd = addr_cmd; // see (R9)
          out_nxt.check = 4'h0;
          ovalid_nxt = 1'b1; // see (R6)
        end
      end
      sysif_pkg::BUS_ADDR:
      begin
        if (is_wr_r)
        begin
          bus_nxt = sysif_pkg::BUS_DATA;
          drive_nxt = 1'b1;
          ovalid_nxt = 1'b1; // see (R6)
          out_nxt.data = wdata_r; // see (R7)
          out_nxt.cmd = data_id; // see (R9)
          out_nxt.check = sysif_pkg::lane_parity(wdata_r); // see (R8)
        end
        else
        begin
          bus_nxt = sysif_pkg::BUS_RD_WAIT;
          rel_nxt = 1'b1; // see (R2)
        end
      end
      sysif_pkg::BUS_DATA:
      begin
        bus_nxt = sysif_pkg::BUS_IDLE;
        drive_nxt = 1'b1;
      end
      sysif_pkg::BUS_RD_WAIT:
      begin
        if (rd_finish)
        begin
          bus_nxt = sysif_pkg::BUS_IDLE;
        end
      end
      sysif_pkg::BUS_SLAVE:
      begin
        if (!ext_req && !in_valid)
        begin
          bus_nxt = sysif_pkg::BUS_IDLE;
        end
      end
    endcase
    if (!core_run)
    begin
      bus_nxt = sysif_pkg::BUS_IDLE; // see (R21)
      ovalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bus_r <= sysif_pkg::BUS_IDLE;
      is_wr_r <= 1'b0;
      out_r <= '0;
      drive_r <= 1'b0;
      ovalid_r <= 1'b0;
      rel_r <= 1'b0;
    end
    else
    begin
      bus_r <= bus_nxt;
      if (bus_r == sysif_pkg::BUS_IDLE)
      begin
        is_wr_r <= start_wr;
      end
      out_r <= out_nxt;
      drive_r <= drive_nxt;
      ovalid_r <= ovalid_nxt;
      rel_r <= rel_nxt;
    end
  end

  assign mux_addr_data_bus_out = out_r.data;
  assign addr_data_check_bus_out = out_r.check;
  assign command_id_bus_out = out_r.cmd;
  assign mux_addr_data_bus_oe = drive_r;
  assign addr_data_check_bus_oe = drive_r;
  assign command_id_bus_oe = drive_r;
  assign command_bus_parity_out = 1'b0; // see (R10)
  assign command_bus_parity_oe = drive_r;
  assign outbound_valid_n = ~ovalid_r; // see (R17)
  assign release_n = ~rel_r; // see (R17)

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  wire [31:0] status_word = {24'h0, busy && bus_r == sysif_pkg::BUS_SLAVE, mode_bad, ext_seen_r, par_err_r,
                             rd_done_r, core_run, boot_done_r, busy};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_addr ? addr_r :
                       hit_wdata ? wdata_r :
                       hit_rdata ? rdata_r :
                       hit_status ? status_word :
                       hit_mode ? {7'h0, rcmd_r, mode_r} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_r <= sysif_pkg::WORD_RST;
      addr_r <= sysif_pkg::WORD_RST;
      wdata_r <= sysif_pkg::WORD_RST;
      rdata_r <= sysif_pkg::WORD_RST;
      rcmd_r <= sysif_pkg::CMD_RST;
      rd_done_r <= 1'b0;
      par_err_r <= 1'b0;
      ext_seen_r <= 1'b0;
      reg_rdata_r <= sysif_pkg::WORD_RST;
    end
    else
    begin
      if (wr_ctrl && !busy)
      begin
        ctrl_r <= reg_wdata & 32'h01ff_1ff0;
      end
      if (reg_wr && hit_addr && !busy)
      begin
        addr_r <= reg_wdata;
      end
      if (reg_wr && hit_wdata && !busy)
      begin
        wdata_r <= reg_wdata;
      end
      if (in_take)
      begin
        rdata_r <= in_s.data;
        rcmd_r <= in_s.cmd; // see (R9) (R10)
      end
      rd_done_r <= rd_finish || (rd_done_r && !(clr_status && reg_wdata[sysif_pkg::STAT_RD_DONE]));
      par_err_r <= (in_take && in_par_bad) || (par_err_r && !(clr_status && reg_wdata[sysif_pkg::STAT_PAR_ERR]));
      ext_seen_r <= (ext_req && core_run) || (ext_seen_r && !(clr_status && reg_wdata[sysif_pkg::STAT_EXT_SEEN]));
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = reg_rdata_r;

endmodule

// ### testbench/sysif_chk.sv
module sysif_chk #(
  parameter int STREAM_BITS = 16
) (
  input wire logic clk, // Reference clock
  input wire logic rstn, // Reset, active low
  input wire logic outbound_valid_n, // Device valid pin
  input wire logic release_n, // Release pin
  input wire logic [31:0] mux_addr_data_bus_out, // Bus output
  input wire logic mux_addr_data_bus_oe, // Bus enable
  input wire logic [3:0] addr_data_check_bus_out, // Check output
  input wire logic addr_data_check_bus_oe, // Check enable
  input wire logic command_id_bus_oe, // Command enable
  input wire logic command_bus_parity_out, // Command parity
  input wire logic command_bus_parity_oe, // Parity enable
  input wire logic boot_serial_clock, // Boot clock
  input wire logic power_on_reset_n, // Cold reset pin
  input wire logic reset_n, // Reset pin
  input wire logic core_reset_n, // Core reset
  input wire logic [3:0] core_clock_factor // Core factor
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] lane_par = {^mux_addr_data_bus_out[31:24], ^mux_addr_data_bus_out[23:16],
    ^mux_addr_data_bus_out[15:8], ^mux_addr_data_bus_out[7:0]};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  chk_cmd_parity: assert property (!command_bus_parity_out && command_bus_parity_oe == command_id_bus_oe)
    else $error("command parity misdriven");
  chk_data_check: assert property (!outbound_valid_n && !$past(outbound_valid_n) |->
    addr_data_check_bus_oe && addr_data_check_bus_out == lane_par)
    else $error("check bus parity wrong");
  chk_valid_drives: assert property (!outbound_valid_n |-> mux_addr_data_bus_oe && command_id_bus_oe)
    else $error("valid word not driven");
  chk_valid_pair: assert property (!outbound_valid_n ##1 !outbound_valid_n |=> outbound_valid_n)
    else $error("too many outbound words");
  chk_release_pulse: assert property ($fell(release_n) |=> release_n)
    else $error("release pulse too long");
  chk_release_bus: assert property (!release_n |-> ##[0:1] !mux_addr_data_bus_oe)
    else $error("bus kept after release");
  chk_core_hold: assert property (!core_reset_n |-> outbound_valid_n)
    else $error("issue while core held");
  chk_boot_div: assert property ($fell(boot_serial_clock) |->
    $past(boot_serial_clock, 128) && !$past(boot_serial_clock, 129))
    else $error("boot clock high phase wrong");
  chk_core_release: assert property ($rose(core_reset_n) |-> $past(reset_n, 2) && $past(power_on_reset_n, 2))
    else $error("core freed while reset pin low");
  chk_factor_stable: assert property (core_reset_n && $past(core_reset_n) |-> $stable(core_clock_factor))
    else $error("factor moved while running");
  cover property ($fell(release_n));
  cover property (!outbound_valid_n ##1 !outbound_valid_n);
  cover property ($rose(core_reset_n));
endmodule

// ### testbench/sysif_agent.sv
module sysif_agent (
  input wire logic clk, // Reference clock
  input wire logic stall, // Refuse new requests
  input wire logic req, // Ask for the bus
  input wire logic [3:0] dly, // Answer delay
  input wire logic [15:0] mode, // Boot word
  input wire logic [40:0] word, // Answer command and data
  input wire logic release_n, // Release pin
  input wire logic boot_serial_clock, // Boot clock
  input wire logic supply_good, // Supply good
  output logic read_accept_n, // Read accept pin
  output logic write_accept_n, // Write accept pin
  output logic ext_request_n, // Request pin
  output logic inbound_valid_n, // Valid pin
  output logic [31:0] mux_addr_data_bus_in, // Bus to device
  output logic [3:0] addr_data_check_bus_in, // Check to device
  output logic [8:0] command_id_bus_in, // Command to device
  output logic boot_mode_data // Boot data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] bit_r = 5'h0;
  logic [3:0] wait_r = 4'h0;
  logic pend_r = 1'h0;
  logic bclk_r = 1'h0;
  assign read_accept_n = stall | pend_r;
  assign write_accept_n = stall | pend_r;
  assign ext_request_n = ~req;
  assign boot_mode_data = bit_r[4] ? 1'h0 : mode[bit_r[3:0]];
  initial
  begin
    inbound_valid_n = 1'h1;
    {command_id_bus_in, mux_addr_data_bus_in} = 41'h0;
    addr_data_check_bus_in = 4'h0;
  end
  // Released lines toggle each cycle so stale data never looks valid
  always @(posedge clk)
  begin
    bclk_r <= boot_serial_clock;
    if (!supply_good)
      bit_r <= 5'h0;
    else if (bclk_r && !boot_serial_clock && !bit_r[4])
      bit_r <= bit_r + 5'h1;
    inbound_valid_n <= 1'h1;
    {command_id_bus_in, mux_addr_data_bus_in} <= ~{command_id_bus_in, mux_addr_data_bus_in};
    addr_data_check_bus_in <= ~addr_data_check_bus_in;
    if (!release_n)
    begin
      pend_r <= 1'h1;
      wait_r <= dly;
    end
    else if (pend_r && wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else if (pend_r)
    begin
      pend_r <= 1'h0;
      inbound_valid_n <= 1'h0;
      {command_id_bus_in, mux_addr_data_bus_in} <= word;
      addr_data_check_bus_in <= {^word[31:24], ^word[23:16], ^word[15:8], ^word[7:0]};
    end
  end
endmodule

// ### testbench/cpu_system_interface_boot_tb.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
`define WAIT_FOR(c, n) for (int i = 0; i < n && !(c); i++) @(posedge clk);
module cpu_system_interface_boot_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic supply_good = 1'h0;
  logic power_on_reset_n = 1'h0;
  logic reset_n = 1'h0;
  logic stall = 1'h0;
  logic req = 1'h0;
  logic [3:0] dly = 4'h0;
  logic [15:0] mode = 16'h0;
  logic [40:0] word = 41'h0;
  logic [31:0] reg_rdata, mux_addr_data_bus_out, mux_addr_data_bus_in, exp_rd;
  logic [8:0] command_id_bus_out, command_id_bus_in;
  logic [3:0] addr_data_check_bus_out, addr_data_check_bus_in, core_clock_factor;
  logic outbound_valid_n, release_n, mux_addr_data_bus_oe, addr_data_check_bus_oe, command_id_bus_oe;
  logic command_bus_parity_out, command_bus_parity_oe, boot_serial_clock, core_reset_n;
  logic ext_request_n, read_accept_n, write_accept_n, inbound_valid_n, boot_mode_data;
  logic rd_d = 1'h0;
  logic [40:0] exp_wd;
  logic [31:0] rq[$];
  logic [40:0] wq[$];
  int fails = 0;
  int checked = 0;
  always #4 clk = ~clk;
  cpu_system_interface_boot #(.STREAM_BITS(16)) cpu_system_interface_boot_inst (.clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_request_n, .read_accept_n, .write_accept_n,
    .inbound_valid_n, .outbound_valid_n, .release_n, .mux_addr_data_bus_in, .mux_addr_data_bus_out,
    .mux_addr_data_bus_oe, .addr_data_check_bus_in, .addr_data_check_bus_out, .addr_data_check_bus_oe,
    .command_id_bus_in, .command_id_bus_out, .command_id_bus_oe, .command_bus_parity_in(1'h1),
    .command_bus_parity_out, .command_bus_parity_oe, .supply_good, .power_on_reset_n, .reset_n,
    .boot_serial_clock, .boot_mode_data, .core_reset_n, .core_clock_factor);
  sysif_agent sysif_agent_inst (.clk, .stall, .req, .dly, .mode, .word, .release_n, .boot_serial_clock,
    .supply_good, .read_accept_n, .write_accept_n, .ext_request_n, .inbound_valid_n, .mux_addr_data_bus_in,
    .addr_data_check_bus_in, .command_id_bus_in, .boot_mode_data);
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
      exp_rd = rq.pop_front();
      `CHK(reg_rdata, exp_rd)
    end
    if (!outbound_valid_n)
    begin
      exp_wd = wq.pop_front();
      `CHK({command_id_bus_out, mux_addr_data_bus_out}, exp_wd)
    end
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test();
  end
  ////////////////////////////////////////
  initial
  begin
    logic [2:0] mu;
    logic [15:0] m;
    logic [31:0] a, d;
    logic [8:0] c, i2;
    void'($urandom(91));
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    reset_n <= 1'h1;
    power_on_reset_n <= 1'h1;
    mu = 3'($urandom_range(6, 0));
    m = {5'h02, 2'h2 | 2'($urandom_range(1, 0)), 1'h0, mu, 4'($urandom_range(8, 0)), 1'h0};
    mode <= m;
    supply_good <= 1'h1;
    `WAIT_FOR(core_reset_n, 6000)
    `CHK(core_reset_n, 1'h1)
    `CHK(core_clock_factor, {1'h0, mu} + 4'h2)
    `CHK(boot_serial_clock, 1'h0)
    rd(sysif_pkg::ADDR_MODE, {16'h0, m});
    rd(sysif_pkg::ADDR_STATUS, 32'h6);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    $display("boot test done");
    for (int k = 0; k < 2; k++)
    begin
      a = $urandom;
      d = $urandom;
      c = 9'($urandom);
      i2 = 9'($urandom);
      stall <= k[0];
      dly <= k[0] ? 4'hf : 4'h0;
      word <= {i2, ~d};
      wr(sysif_pkg::ADDR_ADDR, a);
      wr(sysif_pkg::ADDR_WDATA, d);
      wq.push_back({c, a});
      wq.push_back({i2, d});
      wr(sysif_pkg::ADDR_CTRL, {7'h0, i2, 3'h0, c, 4'h2});
      if (k[0])
      begin
        rd(sysif_pkg::ADDR_STATUS, 32'h7);
        repeat (20) @(posedge clk);
        `CHK(wq.size(), 2)
        stall <= 1'h0;
      end
      `WAIT_FOR(wq.size() == 0, 100)
      wq.push_back({c, a});
      wr(sysif_pkg::ADDR_CTRL, {19'h0, c, 4'h1});
      `WAIT_FOR(!inbound_valid_n, 100)
      repeat (4) @(posedge clk);
      rd(sysif_pkg::ADDR_RDATA, ~d);
      rd(sysif_pkg::ADDR_MODE, {7'h0, i2, m});
      rd(sysif_pkg::ADDR_STATUS, 32'he);
      wr(sysif_pkg::ADDR_STATUS, 32'h8);
      $display("transfer test %0d done", k);
    end
    req <= 1'h1;
    `WAIT_FOR(!release_n, 50)
    `CHK(release_n, 1'h0)
    `WAIT_FOR(!inbound_valid_n, 50)
    req <= 1'h0;
    repeat (6) @(posedge clk);
    rd(sysif_pkg::ADDR_STATUS, 32'h26);
    wr(sysif_pkg::ADDR_STATUS, 32'h20);
    reset_n <= 1'h0;
    `WAIT_FOR(!core_reset_n, 10)
    `CHK(core_reset_n, 1'h0)
    reset_n <= 1'h1;
    `WAIT_FOR(core_reset_n, 10)
    `CHK(core_clock_factor, {1'h0, mu} + 4'h2)
    rd(sysif_pkg::ADDR_MODE, {7'h0, i2, m});
    $display("slave and warm reset tests done");
    supply_good <= 1'h0;
    power_on_reset_n <= 1'h0;
    m = {5'h02, 2'h1, 1'h0, 3'h7, 4'hf, 1'h0};
    mode <= m;
    repeat (4) @(posedge clk);
    supply_good <= 1'h1;
    power_on_reset_n <= 1'h1;
    @(posedge clk);
    `WAIT_FOR(core_reset_n, 6000)
    `CHK(core_clock_factor, 4'h0)
    rd(sysif_pkg::ADDR_STATUS, 32'h46);
    $display("reserved mode test done");
    finish_test();
  end
endmodule
bind cpu_system_interface_boot sysif_chk #(.STREAM_BITS(STREAM_BITS)) sysif_chk_inst (.clk, .rstn,
  .outbound_valid_n, .release_n, .mux_addr_data_bus_out, .mux_addr_data_bus_oe, .addr_data_check_bus_out,
  .addr_data_check_bus_oe, .command_id_bus_oe, .command_bus_parity_out, .command_bus_parity_oe,
  .boot_serial_clock, .power_on_reset_n, .reset_n, .core_reset_n, .core_clock_factor);
